// [common/dip_defs.svh]
// register offsets, field positions and reset values of the input image packer
// assumes byte addressing on an 8-bit register port with 32-bit data words
`ifndef DIP_DEFS_SVH
`define DIP_DEFS_SVH

`define DIP_REG_CTRL 8'h00
`define DIP_REG_KINDS 8'h04
`define DIP_REG_STATUS 8'h08
`define DIP_REG_IRQ_STAT 8'h0C
`define DIP_REG_IRQ_MASK 8'h10
`define DIP_IMG_BASE 8'h40

`define DIP_CTRL_EN_BIT 0
`define DIP_CTRL_CNT_LSB 8
`define DIP_CTRL_EN_RST 1'b1
`define DIP_CTRL_CNT_RST 8'h00
`define DIP_KINDS_RST 32'h0000_0000
`define DIP_IRQ_MASK_RST 2'h0

`define DIP_IRQ_SNAP_BIT 0
`define DIP_IRQ_FAULT_BIT 1

`define DIP_BIT_STATE1 0
`define DIP_BIT_STATE2 1
`define DIP_BIT_FAULT_1CH 1
`define DIP_BIT_FAULT1 2
`define DIP_BIT_FAULT2 3

`endif

// [common/dip_pkg.sv]
// types shared by the input image packer
// assumes nothing beyond the constants header
package dip_pkg;

    // layout kind of one module slot on the local bus
    typedef enum logic [1:0] {
        DIP_KIND_NONE = 2'b00,
        DIP_KIND_1CH_DIAG = 2'b01,
        DIP_KIND_2CH = 2'b10,
        DIP_KIND_2CH_DIAG = 2'b11
    } dip_mod_kind_type;

endpackage : dip_pkg

// [rtl/dip_packer.sv]
// digital input image packer: snapshots module channel states into the input image
// assumes inputs synchronous to clk and a one-cycle local-bus update pulse
`timescale 1ns/1ns
`include "dip_defs.svh"

module dip_packer #(
    parameter int NUM_MOD = 8,
    parameter int ANA_MAX = 4
) (
    // clock, reset, enable
    input wire logic clk,
    input wire logic rst_b,
    input wire logic ce,
    // register port
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata,
    // local-bus module inputs
    input wire logic bus_update,
    input wire logic [NUM_MOD-1:0] input_state_ch1,
    input wire logic [NUM_MOD-1:0] input_state_ch2,
    input wire logic [NUM_MOD-1:0] fault_ch1,
    input wire logic [NUM_MOD-1:0] fault_ch2,
    input wire logic [ANA_MAX*16-1:0] ana_data,
    // interrupt
    output logic irq
);

    localparam int IMG_WORDS = ANA_MAX + (NUM_MOD + 1) / 2;
    localparam int IMG_BITS = IMG_WORDS * 16;
    localparam logic [7:0] ANA_MAX_8 = 8'(ANA_MAX);
    localparam logic [7:0] IMG_END = 8'(`DIP_IMG_BASE + 4 * IMG_WORDS);

    typedef struct packed {
        logic en;
        logic [7:0] ana_cnt;
        logic [2*NUM_MOD-1:0] kinds;
        logic [15:0] snap_cnt;
        logic [1:0] irq_stat;
        logic [1:0] irq_mask;
        logic [NUM_MOD*2-1:0] fault_seen;
        logic [31:0] rdata;
        logic [IMG_BITS-1:0] img;
    } dip_state_type;

    dip_state_type q;
    dip_state_type d;
    logic [IMG_BITS-1:0] next_img;
    logic [NUM_MOD*2-1:0] next_faults;
    logic snap;

    // one module byte from its kind and channel bits
    function automatic logic [7:0] mod_byte(
        input dip_pkg::dip_mod_kind_type kind,
        input logic s1,
        input logic s2,
        input logic f1,
        input logic f2
    );
        logic [7:0] b;
        b = 8'h00;
        unique case (kind)
            dip_pkg::DIP_KIND_NONE: begin
                b = 8'h00;
            end
            dip_pkg::DIP_KIND_1CH_DIAG: begin
                b[`DIP_BIT_STATE1] = s1;
                b[`DIP_BIT_FAULT_1CH] = f1;
            end
            dip_pkg::DIP_KIND_2CH: begin
                b[`DIP_BIT_STATE1] = s1;
                b[`DIP_BIT_STATE2] = s2;
            end
            dip_pkg::DIP_KIND_2CH_DIAG: begin
                b[`DIP_BIT_STATE1] = s1;
                b[`DIP_BIT_STATE2] = s2;
                b[`DIP_BIT_FAULT1] = f1;
                b[`DIP_BIT_FAULT2] = f2;
            end
        endcase
        return b;
    endfunction : mod_byte

    // fault bits that count for a slot's kind
    function automatic logic [1:0] kind_faults(
        input dip_pkg::dip_mod_kind_type kind,
        input logic f1,
        input logic f2
    );
        logic [1:0] f;
        f = 2'b00;
        if (kind == dip_pkg::DIP_KIND_1CH_DIAG) begin
            f = {1'b0, f1};
        end else if (kind == dip_pkg::DIP_KIND_2CH_DIAG) begin
            f = {f2, f1};
        end
        return f;
    endfunction : kind_faults

    // whole image: analog words, then one byte per present module
    function automatic logic [IMG_BITS-1:0] build_image(
        input logic [7:0] cnt,
        input logic [2*NUM_MOD-1:0] kinds,
        input logic [NUM_MOD-1:0] s1,
        input logic [NUM_MOD-1:0] s2,
        input logic [NUM_MOD-1:0] f1,
        input logic [NUM_MOD-1:0] f2,
        input logic [ANA_MAX*16-1:0] ana
    );
        logic [IMG_BITS-1:0] img;
        dip_pkg::dip_mod_kind_type kind;
        int b;
        img = '0;
        // analog words, low byte at even address
        for (int i = 0; i < ANA_MAX; i++) begin
            if (i < int'(cnt)) begin
                img[i*16 +: 16] = ana[i*16 +: 16];
            end
        end
        b = 2 * int'(cnt);
        for (int k = 0; k < NUM_MOD; k++) begin
            kind = dip_pkg::dip_mod_kind_type'(kinds[2*k +: 2]);
            if (kind != dip_pkg::DIP_KIND_NONE) begin
                // state and fault bits per channel
                img[b*8 +: 8] = mod_byte(kind, s1[k], s2[k], f1[k], f2[k]);
                b = b + 1;
            end
        end
        return img;
    endfunction : build_image

    // register read decode; image words sit in the low half
    function automatic logic [31:0] reg_read(input logic [7:0] a, input dip_state_type s);
        logic [31:0] r;
        logic [7:0] off;
        r = 32'h0000_0000;
        off = a - `DIP_IMG_BASE;
        if (a == `DIP_REG_CTRL) begin
            r[`DIP_CTRL_EN_BIT] = s.en;
            r[`DIP_CTRL_CNT_LSB +: 8] = s.ana_cnt;
        end else if (a == `DIP_REG_KINDS) begin
            r[2*NUM_MOD-1:0] = s.kinds;
        end else if (a == `DIP_REG_STATUS) begin
            r[15:0] = s.snap_cnt;
        end else if (a == `DIP_REG_IRQ_STAT) begin
            r[1:0] = s.irq_stat;
        end else if (a == `DIP_REG_IRQ_MASK) begin
            r[1:0] = s.irq_mask;
        end else if (a >= `DIP_IMG_BASE && a < IMG_END && a[1:0] == 2'b00) begin
            r[15:0] = s.img[int'(off[7:2])*16 +: 16];
        end
        return r;
    endfunction : reg_read

    assign next_img = build_image(q.ana_cnt, q.kinds, input_state_ch1, input_state_ch2,
        fault_ch1, fault_ch2, ana_data);

    always_comb begin
        for (int k = 0; k < NUM_MOD; k++) begin
            next_faults[2*k +: 2] = kind_faults(dip_pkg::dip_mod_kind_type'(q.kinds[2*k +: 2]),
                fault_ch1[k], fault_ch2[k]);
        end
    end

    // snapshots stop while software disables the packer
    assign snap = q.en && bus_update;

    always_comb begin
        d = q;
        d.rdata = rd ? reg_read(addr, q) : 32'h0000_0000;
        if (wr && addr == `DIP_REG_CTRL) begin
            d.en = wdata[`DIP_CTRL_EN_BIT];
            // too many analog words would push digital bytes off the image
            d.ana_cnt = (wdata[`DIP_CTRL_CNT_LSB +: 8] > ANA_MAX_8) ? ANA_MAX_8
                : wdata[`DIP_CTRL_CNT_LSB +: 8];
        end
        if (wr && addr == `DIP_REG_KINDS) begin
            d.kinds = wdata[2*NUM_MOD-1:0];
        end
        if (wr && addr == `DIP_REG_IRQ_MASK) begin
            d.irq_mask = wdata[1:0];
        end
        if (wr && addr == `DIP_REG_IRQ_STAT) begin
            d.irq_stat = q.irq_stat & ~wdata[1:0];
        end
        if (snap) begin
            d.img = next_img;
            d.snap_cnt = q.snap_cnt + 16'h0001;
            d.fault_seen = next_faults;
            // set after clear so a same-cycle event survives
            d.irq_stat[`DIP_IRQ_SNAP_BIT] = 1'b1;
            if ((next_faults & ~q.fault_seen) != '0) begin
                d.irq_stat[`DIP_IRQ_FAULT_BIT] = 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            q <= '0;
            q.en <= `DIP_CTRL_EN_RST;
            q.ana_cnt <= `DIP_CTRL_CNT_RST;
            q.kinds <= (2*NUM_MOD)'(`DIP_KINDS_RST);
            q.irq_mask <= `DIP_IRQ_MASK_RST;
        end else if (ce) begin
            q <= d;
        end
    end

    assign rdata = q.rdata;
    assign irq = |(q.irq_stat & q.irq_mask);

    default clocking dip_cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);

    // a count write beside a snapshot would move the first module byte
    logic snap_steady;
    logic [7:0] first_mod_byte;
    assign snap_steady = ce && snap && !(wr && addr == `DIP_REG_CTRL);
    assign first_mod_byte = q.img[int'(q.ana_cnt)*16 +: 8];

    chk_image_whole_snap: assert property (
        ce && snap |=> q.img == $past(next_img)
    ) else $error("image differs from snapshot taken");

    chk_analog_then_digital: assert property (
        ce && snap && q.ana_cnt == 8'h01 && q.kinds[1:0] != 2'b00
        |=> q.img[15:0] == $past(ana_data[15:0]) && q.img[16] == $past(input_state_ch1[0])
    ) else $error("digital byte not after analog word");

    chk_word_little_endian: assert property (
        ce && snap && q.ana_cnt == 8'h00 && q.kinds[1:0] != 2'b00 && q.kinds[3:2] != 2'b00
        |=> q.img[8] == $past(input_state_ch1[1]) && q.img[0] == $past(input_state_ch1[0])
    ) else $error("second module byte not in high half");

    chk_state_bit_zero: assert property (
        snap_steady && q.kinds[1:0] != 2'b00
        |=> first_mod_byte[0] == $past(input_state_ch1[0])
    ) else $error("channel state missing from bit 0");

    chk_one_chan_diag: assert property (
        snap_steady && q.kinds[1:0] == 2'b01
        |=> first_mod_byte[1] == $past(fault_ch1[0]) && first_mod_byte[7:2] == 6'h00
    ) else $error("one channel fault bit misplaced");

    chk_two_chan_plain: assert property (
        snap_steady && q.kinds[1:0] == 2'b10
        |=> first_mod_byte[1:0] == {$past(input_state_ch2[0]), $past(input_state_ch1[0])}
    ) else $error("two channel states misplaced");

    chk_two_chan_diag: assert property (
        snap_steady && q.kinds[1:0] == 2'b11
        |=> first_mod_byte[3:2] == {$past(fault_ch2[0]), $past(fault_ch1[0])}
    ) else $error("two channel fault bits misplaced");

    chk_fault_flag_rise: assert property (
        ce && snap && q.kinds[0] && fault_ch1[0] && !q.fault_seen[0]
        |=> q.irq_stat[`DIP_IRQ_FAULT_BIT]
    ) else $error("new fault not flagged");

    chk_unused_bits_zero: assert property (
        snap_steady && q.kinds[1:0] == 2'b10
        |=> first_mod_byte[7:2] == 6'h00
    ) else $error("unassigned image bits not zero");

    chk_image_held: assert property (
        !(ce && snap) |=> $stable(q.img)
    ) else $error("image changed outside an update");

    chk_read_one_cycle: assert property (
        ce && rd && addr == `DIP_REG_STATUS
        |=> rdata == {16'h0000, $past(q.snap_cnt)} ##1 ($past(rd) || !$past(ce) || rdata == 32'h0)
    ) else $error("status read data misplaced");

    // set wins over a same-cycle clear
    chk_set_beats_clear: assert property (
        ce && snap && wr && addr == `DIP_REG_IRQ_STAT |=> q.irq_stat[`DIP_IRQ_SNAP_BIT]
    ) else $error("snapshot flag lost to a clear");

    chk_enable_freeze: assert property (
        !ce |=> $stable(q)
    ) else $error("state moved while clock enable low");

    cov_snap_with_analog: cover property (ce && snap && q.ana_cnt != 8'h00);
    cov_irq_raised: cover property (!irq ##1 irq);
    cov_clear_meets_set: cover property (ce && snap && wr && addr == `DIP_REG_IRQ_STAT && wdata[0]);
    cov_update_while_frozen: cover property (!ce && bus_update && q.en);

endmodule : dip_packer

// [testbench/dip_mod_model.sv]
// behavioural digital input modules on the local bus
// assumes the bench requests one update at a time through go
`timescale 1ns/1ns
module dip_mod_model #(
    parameter int NUM_MOD = 4
) (
    // clock, reset
    input wire logic clk,
    input wire logic rst_b,
    // bench request, pattern is {fault2, fault1, state2, state1}
    input wire logic go,
    input wire logic [4*NUM_MOD-1:0] pat,
    // module side
    output logic bus_update,
    output logic [NUM_MOD-1:0] input_state_ch1,
    output logic [NUM_MOD-1:0] input_state_ch2,
    output logic [NUM_MOD-1:0] fault_ch1,
    output logic [NUM_MOD-1:0] fault_ch2
);
    // faults of plain slots are driven too, the packer must drop them
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            bus_update <= 1'b0;
            {fault_ch2, fault_ch1, input_state_ch2, input_state_ch1} <= '0;
        end else begin
            bus_update <= go;
            if (go) begin
                {fault_ch2, fault_ch1, input_state_ch2, input_state_ch1} <= pat;
            end
        end
    end
endmodule : dip_mod_model

// [testbench/dip_packer_bench.sv]
// self-checking bench of the input image packer
// assumes the packer's register map header and a behavioural module model
`timescale 1ns/1ns
`include "dip_defs.svh"
module dip_packer_bench;
    localparam int NM = 4;
    localparam int AM = 2;
    typedef struct packed {
        logic [7:0] kinds;
        logic [7:0] cnt;
        logic [15:0] pat;
        logic [31:0] ana;
        logic [63:0] img;
    } dip_row_type;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic ce = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic go = 1'b0;
    logic [15:0] pat = 16'h0;
    logic [AM*16-1:0] ana_data = '0;
    logic [31:0] rdata;
    logic bus_update;
    logic irq;
    logic [NM-1:0] s1, s2, f1, f2;
    int err_count = 0;
    int checks_done = 0;
    int cycles = 0;
    dip_row_type rows [4];

    dip_packer #(.NUM_MOD(NM), .ANA_MAX(AM)) dip_packer_i (.clk(clk), .rst_b(rst_b), .ce(ce),
        .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .bus_update(bus_update),
        .input_state_ch1(s1), .input_state_ch2(s2), .fault_ch1(f1), .fault_ch2(f2),
        .ana_data(ana_data), .irq(irq));
    dip_mod_model #(.NUM_MOD(NM)) dip_mod_model_i (.clk(clk), .rst_b(rst_b), .go(go), .pat(pat),
        .bus_update(bus_update), .input_state_ch1(s1), .input_state_ch2(s2), .fault_ch1(f1),
        .fault_ch2(f2));

    always #5 clk = ~clk;

    task automatic tally_and_finish();
        $display("checks %0d errors %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : tally_and_finish

    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            err_count++;
            $display("ERROR timeout expected end seen hang");
            tally_and_finish();
        end
    end

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string what);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        check(what, exp, rdata);
    endtask : rd_chk

    // pulse lands one cycle after go; irq is looked at on the falling edge two cycles later
    task automatic snap(input logic [15:0] p);
        @(posedge clk);
        go <= 1'b1;
        pat <= p;
        @(posedge clk);
        go <= 1'b0;
        repeat (2) @(posedge clk);
        @(negedge clk);
    endtask : snap

    initial begin
        rows[0] = '{8'h39, 8'h00, 16'hFFFF, 32'h0, 64'h0000_0000_000F_0303};
        rows[1] = '{8'hFF, 8'h02, 16'h1835, 32'hBEEF_1234, 64'h0401_020B_BEEF_1234};
        rows[2] = '{8'hAA, 8'h01, 16'hFF6A, 32'h7777_A55A, 64'h0000_0102_0300_A55A};
        rows[3] = '{8'h55, 8'h03, 16'hFAFC, 32'h00FF_8001, 64'h0301_0200_00FF_8001};
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        rd_chk(`DIP_REG_CTRL, 32'h0000_0001, "ctrl reset");
        rd_chk(`DIP_IMG_BASE, 32'h0, "image reset");
        foreach (rows[i]) begin
            wr_reg(`DIP_REG_KINDS, {24'h0, rows[i].kinds});
            wr_reg(`DIP_REG_CTRL, {16'h0, rows[i].cnt, 8'h01});
            ana_data <= rows[i].ana;
            snap(rows[i].pat);
            for (int w = 0; w < 4; w++) begin
                rd_chk(`DIP_IMG_BASE + 8'(4 * w), {16'h0, rows[i].img[16*w +: 16]}, "image");
            end
            rd_chk(`DIP_REG_STATUS, 32'(i + 1), "snapshot count");
        end
        check("irq masked", 32'h0, {31'h0, irq});
        rd_chk(`DIP_REG_IRQ_STAT, 32'h3, "irq status");
        wr_reg(`DIP_REG_IRQ_STAT, 32'h3);
        rd_chk(`DIP_REG_IRQ_STAT, 32'h0, "irq cleared");
        wr_reg(`DIP_REG_IRQ_MASK, 32'h3);
        snap(16'hFFFC);
        check("irq raised", 32'h1, {31'h0, irq});
        rd_chk(`DIP_REG_IRQ_STAT, 32'h3, "fault event");
        rd_chk(`DIP_IMG_BASE + 8'h08, 32'h0202, "image w2");
        @(posedge clk);
        ce <= 1'b0;
        snap(16'h0000);
        @(posedge clk);
        ce <= 1'b1;
        rd_chk(`DIP_IMG_BASE + 8'h0C, 32'h0303, "frozen image");
        @(posedge clk);
        go <= 1'b1;
        pat <= 16'hFFFC;
        @(posedge clk);
        go <= 1'b0;
        addr <= `DIP_REG_IRQ_STAT;
        wdata <= 32'h3;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        rd_chk(`DIP_REG_IRQ_STAT, 32'h1, "set beats clear");
        wr_reg(`DIP_REG_CTRL, 32'h0);
        snap(16'h0000);
        rd_chk(`DIP_REG_STATUS, 32'h6, "count held");
        rd_chk(`DIP_IMG_BASE + 8'h0C, 32'h0303, "held image");
        rd_chk(8'h20, 32'h0, "unmapped");
        rd_chk(`DIP_IMG_BASE + 8'h01, 32'h0, "unaligned");
        wr_reg(`DIP_REG_IRQ_STAT, 32'h3);
        @(negedge clk);
        check("irq low", 32'h0, {31'h0, irq});
        @(posedge clk);
        rst_b <= 1'b0;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        rd_chk(`DIP_REG_CTRL, 32'h0000_0001, "ctrl after reset");
        rd_chk(`DIP_REG_STATUS, 32'h0, "count after reset");
        rd_chk(`DIP_IMG_BASE + 8'h0C, 32'h0, "image after reset");
        tally_and_finish();
    end
endmodule : dip_packer_bench
